//--- include/acf_pkg.sv
// converter configuration and result formatting: constants, field layouts and types
// assumes one system clock, an AHB-Lite master with whole-word single transfers
// Overview of operation
// - conversion clock period is divider field (bits 7:3) plus one system clocks
// - configuration bit 2 picks left (1) or right (0) result alignment
// - configuration bit 1 picks 8-bit mode; alignment bit is then ignored
// - configuration bit 0 sets gain: 0 gives one half, 1 gives unity
// - right aligned 10-bit: high byte holds zeros above two top result bits
// - left aligned 10-bit: high byte holds eight top result bits
// - right aligned 10-bit: low byte holds eight low result bits
// - left aligned 10-bit: low byte bits 7:6 hold two low bits, rest zero
// - 8-bit mode: high byte holds the result, low byte reads zero
// - 8-bit conversion takes two fewer conversion clocks, resolving only eight top bits
// - results are unsigned and both bytes update at every conversion end
package acf_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_CONFIGURATION = 8'hBC;
	localparam logic [7:0] IDX_RESULT_LOW = 8'hBD;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'hBE;
	localparam logic [7:0] IDX_CONTROL = 8'hC0;
	localparam int ADDR_LSB = 2;
	localparam int INDEX_WIDTH = 8;
	// configuration fields and reset value
	localparam logic [7:0] CONFIGURATION_RESET = 8'hF9;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam int DIVIDER_MSB = 7;
	localparam int DIVIDER_LSB = 3;
	localparam int LEFT_JUSTIFY_BIT = 2;
	localparam int EIGHT_BIT_BIT = 1;
	localparam int GAIN_BIT = 0;
	// control register fields
	localparam int CONTROL_START_BUSY_BIT = 0;
	localparam int CONTROL_DONE_BIT = 1;
	// converter sizes
	localparam int RESULT_WIDTH = 10;
	localparam logic [3:0] BITS_TEN = 4'hA;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic [4:0] sar_clock_divider;
		logic left_justify_select;
		logic eight_bit_mode_enable;
		logic gain_select;
	} acf_config_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [INDEX_WIDTH-1:0] index;
	} acf_bus_phase_type;

	typedef enum logic [2:0] {
		ACF_IDLE = 3'b001,
		ACF_CONVERT = 3'b010,
		ACF_STORE = 3'b100
	} acf_state_type;
endpackage : acf_pkg

//--- verilog/acf_converter.sv
// converter configuration, conversion clock, SAR sequencer and result formatting
// assumes an AHB-Lite master on the same clock and an analog comparator whose
// output is synchronous to the clock and settles within one conversion clock
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acf_converter
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic comparator_high,
	output logic [acf_pkg::RESULT_WIDTH-1:0] sar_dac_code,
	output logic sample_hold,
	output logic gain_select,
	output logic conversion_clock
);
	import acf_pkg::*;

	acf_config_type converter_configuration;
	logic [7:0] result_low_byte;
	logic [7:0] result_high_byte;
	acf_bus_phase_type data_phase;
	logic [4:0] divider_count;
	logic conversion_tick;
	acf_state_type state;
	acf_state_type next_state;
	logic [3:0] bits_left;
	logic [RESULT_WIDTH-1:0] trial_bit;
	logic conversion_done;
	logic write_configuration;
	logic write_result_low;
	logic write_result_high;
	logic write_control;
	logic start_request;
	logic done_clear;
	logic [7:0] next_low;
	logic [7:0] next_high;

	////////////////////////////////////////////////////////////////////////////////
	// bus slave

	// never stalls, so every transfer completes with zero wait states
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	// capture the address phase; hsize is ignored because only whole words are used
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			data_phase <= '0;
		end
		else if (hready)
		begin
			data_phase.valid <= hsel && (htrans == HTRANS_NONSEQ);
			data_phase.write <= hwrite;
			data_phase.index <= haddr[ADDR_LSB +: INDEX_WIDTH];
		end
	end

	// write strobes in the data phase; unmapped indexes are ignored
	always_comb
	begin
		write_configuration = data_phase.valid && data_phase.write && (data_phase.index == IDX_CONFIGURATION);
		write_result_low = data_phase.valid && data_phase.write && (data_phase.index == IDX_RESULT_LOW);
		write_result_high = data_phase.valid && data_phase.write && (data_phase.index == IDX_RESULT_HIGH);
		write_control = data_phase.valid && data_phase.write && (data_phase.index == IDX_CONTROL);
		start_request = write_control && hwdata[CONTROL_START_BUSY_BIT];
		done_clear = write_control && hwdata[CONTROL_DONE_BIT];
	end

	// read mux over stored flops, so a write lands before a following read sees it
	// unmapped indexes read zero, so software can probe the map without side effects
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (data_phase.valid && !data_phase.write)
		begin
			unique case (data_phase.index)
				IDX_CONFIGURATION: hrdata = {24'h00_0000, converter_configuration};
				IDX_RESULT_LOW: hrdata = {24'h00_0000, result_low_byte};
				IDX_RESULT_HIGH: hrdata = {24'h00_0000, result_high_byte};
				IDX_CONTROL: hrdata = {30'h0000_0000, conversion_done, (state != ACF_IDLE)};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration register

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			converter_configuration <= CONFIGURATION_RESET;
		end
		else if (write_configuration)
		begin
			converter_configuration <= hwdata[7:0];
		end
	end

	// gain stage follows bit 0 directly
	assign gain_select = converter_configuration.gain_select;

	////////////////////////////////////////////////////////////////////////////////
	// conversion clock

	// reload with the divider field: a tick every divider+1 system clocks;
	// an enable, not a real clock, keeps everything in one domain
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			divider_count <= '0;
		end
		else if (divider_count == 5'h00)
		begin
			divider_count <= converter_configuration.sar_clock_divider;
		end
		else
		begin
			divider_count <= divider_count - 5'h01;
		end
	end

	// divider zero gives a tick every cycle; software keeps it nonzero where needed
	assign conversion_tick = (divider_count == 5'h00);
	assign conversion_clock = conversion_tick;

	////////////////////////////////////////////////////////////////////////////////
	// SAR sequencer

	// a start while busy is ignored; software must poll busy before the next start
	always_comb
	begin
		next_state = state;
		unique case (state)
			ACF_IDLE:
			begin
				if (start_request)
				begin
					next_state = ACF_CONVERT;
				end
			end
			ACF_CONVERT:
			begin
				if (conversion_tick && bits_left == 4'h1)
				begin
					next_state = ACF_STORE;
				end
			end
			ACF_STORE:
			begin
				next_state = ACF_IDLE;
			end
			default:
			begin
				next_state = ACF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= ACF_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// tracking whenever no conversion runs
	assign sample_hold = (state != ACF_IDLE);

	// bit counter and trial bit walk one place per conversion clock
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			bits_left <= '0;
			trial_bit <= '0;
		end
		else if (state == ACF_IDLE && start_request)
		begin
			bits_left <= converter_configuration.eight_bit_mode_enable ? BITS_EIGHT : BITS_TEN;
			trial_bit <= {1'b1, {(RESULT_WIDTH-1){1'b0}}};
		end
		else if (state == ACF_CONVERT && conversion_tick)
		begin
			bits_left <= bits_left - 4'h1;
			trial_bit <= trial_bit >> 1;
		end
	end

	// one result bit per conversion clock, eight bits in 8-bit mode;
	// the code holds between conversions so the store cycle formats the final value
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sar_dac_code <= '0;
		end
		else if (state == ACF_IDLE && start_request)
		begin
			sar_dac_code <= {1'b1, {(RESULT_WIDTH-1){1'b0}}};
		end
		else if (state == ACF_CONVERT && conversion_tick)
		begin
			// keep the trial bit when the input is at or above it, then try the next one
			sar_dac_code <= (comparator_high ? sar_dac_code : (sar_dac_code & ~trial_bit))
				| ((bits_left == 4'h1) ? '0 : (trial_bit >> 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// result formatting

	// unsigned code placed per resolution and alignment
	always_comb
	begin
		if (converter_configuration.eight_bit_mode_enable)
		begin
			next_high = sar_dac_code[9:2];
			next_low = 8'h00;
		end
		else if (converter_configuration.left_justify_select)
		begin
			next_high = sar_dac_code[9:2];
			next_low = {sar_dac_code[1:0], 6'h00};
		end
		else
		begin
			next_high = {6'h00, sar_dac_code[9:8]};
			next_low = sar_dac_code[7:0];
		end
	end

	// low byte: completion overrides a software write in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			result_low_byte <= RESULT_RESET;
		end
		else if (state == ACF_STORE)
		begin
			result_low_byte <= next_low;
		end
		else if (write_result_low)
		begin
			result_low_byte <= hwdata[7:0];
		end
	end

	// high byte: same priority, a fresh result matters more than a stray write
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			result_high_byte <= RESULT_RESET;
		end
		else if (state == ACF_STORE)
		begin
			result_high_byte <= next_high;
		end
		else if (write_result_high)
		begin
			result_high_byte <= hwdata[7:0];
		end
	end

	// sticky completion flag; set wins over a clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			conversion_done <= 1'b0;
		end
		else if (state == ACF_STORE)
		begin
			conversion_done <= 1'b1;
		end
		else if (done_clear)
		begin
			conversion_done <= 1'b0;
		end
	end
endmodule : acf_converter
`default_nettype wire

//--- bench/acf_props.sv
// port-level checks for the converter configuration and result block
// assumes a bind from tb_top and the one system clock
`timescale 1ns/1ps
`default_nettype none
module acf_props
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic sample_hold,
	input wire logic gain_select,
	input wire logic conversion_clock
);
	import acf_pkg::*;
	logic wr_cfg, wr_ctl, rd_any;
	logic [4:0] div;
	wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
	// data-phase flags, one cycle behind the address phase
	always_ff @(posedge clock)
	begin
		wr_cfg <= !rst && take && hwrite && haddr[9:2] == IDX_CONFIGURATION;
		wr_ctl <= !rst && take && hwrite && haddr[9:2] == IDX_CONTROL;
		rd_any <= !rst && take && !hwrite;
	end
	// divider shadow: a zero divider ticks every clock, so the gap check skips it
	always_ff @(posedge clock)
	begin
		if (rst)
			div <= CONFIGURATION_RESET[7:3];
		else if (wr_cfg)
			div <= hwdata[7:3];
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// idle start only; a start in the store cycle would be ignored
	sequence start_s;
		wr_ctl && hwdata[0] && !sample_hold && !$past(sample_hold);
	endsequence
	bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
	bus_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
	idle_data_a: assert property (!rd_any |-> hrdata == 32'h0) else $error("hrdata outside read");
	upper_zero_a: assert property (rd_any |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
	gain_follow_a: assert property (wr_cfg |=> gain_select == $past(hwdata[GAIN_BIT]))
		else $error("gain not taken");
	start_hold_a: assert property (start_s |=> sample_hold [*8]) else $error("conversion too short");
	conv_bound_a: assert property ($rose(sample_hold) |-> ##[8:400] !sample_hold)
		else $error("conversion never ends");
	tick_gap_a: assert property (conversion_clock && div != 5'h0 |=> !conversion_clock)
		else $error("ticks back to back");
endmodule : acf_props
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench: registers over AHB-Lite, comparator modelled from vin
// assumes acf_pkg and acf_converter compiled first; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import acf_pkg::*;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0, comparator_high = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, sample_hold, gain_select, conversion_clock;
	logic [9:0] sar_dac_code, vin = 0;
	logic [7:0] cfg;
	logic [15:0] e;
	int fails = 0, total_checks = 0, cycles = 0, ticks = 0, gap = 0, last = 0, tick_base = 0;
	acf_converter u_acf_converter (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .comparator_high(comparator_high), .sar_dac_code(sar_dac_code),
		.sample_hold(sample_hold), .gain_select(gain_select), .conversion_clock(conversion_clock));
	initial forever #50 clock = ~clock;
	// comparator settles in the step the code changes, so even the first tick sees the trial code
	always @(sar_dac_code or vin or gain_select)
		comparator_high <= (gain_select ? vin : vin >> 1) >= sar_dac_code;
	// tick spacing, ticks inside a conversion, and the hang limit
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (conversion_clock)
		begin
			gap <= cycles - last;
			last <= cycles;
			if (sample_hold)
				ticks <= ticks + 1;
		end
		if (cycles > 20000)
			summarize(1);
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one single transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1)
			@(posedge clock);
		rd = hrdata;
	endtask : xfer
	function automatic logic [15:0] expect_fmt(input logic [7:0] c, input logic [9:0] v);
		logic [9:0] r;
		r = c[0] ? v : v >> 1;
		if (c[1])
			return {r[9:2], 8'h0};
		if (c[2])
			return {r, 6'h0};
		return {6'h0, r};
	endfunction : expect_fmt
	task automatic summarize(input bit hung);
		if (hung)
			fails++;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h08FE4F22));
		repeat (3) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		xfer(0, IDX_CONFIGURATION, 0);
		check("config reset", rd, {24'h0, CONFIGURATION_RESET});
		xfer(0, IDX_RESULT_LOW, 0);
		check("low reset", rd, 32'h0);
		xfer(1, 8'h10, 32'hFF);
		xfer(0, 8'h10, 0);
		check("unmapped", rd, 32'h0);
		xfer(1, IDX_RESULT_HIGH, 32'h5A);
		xfer(0, IDX_RESULT_HIGH, 0);
		check("high rw", rd, 32'h5A);
		for (int i = 0; i < 14; i++)
		begin
			cfg = 8'($urandom);
			if (i < 8)
				cfg[2:0] = 3'(i);
			cfg[7:3] = (i == 1) ? 5'h1F : 5'(1 + $urandom % 3);
			vin <= (i == 0) ? 10'h0 : (i == 1) ? 10'h3FF : 10'($urandom);
			xfer(1, IDX_CONFIGURATION, {24'h0, cfg});
			xfer(0, IDX_CONFIGURATION, 0);
			check("config", rd, {24'h0, cfg});
			check("gain", gain_select, cfg[0]);
			repeat (4) @(posedge conversion_clock);
			check("tick gap", gap, cfg[7:3] + 1);
			tick_base = ticks;
			xfer(1, IDX_CONTROL, 32'h1);
			// a second start while busy must not restart the conversion
			xfer(1, IDX_CONTROL, 32'h1);
			do
				xfer(0, IDX_CONTROL, 0);
			while (rd[0] === 1'b1);
			check("done", rd[1], 1'b1);
			check("ticks", ticks - tick_base, cfg[1] ? 8 : 10);
			xfer(1, IDX_CONTROL, 32'h2);
			xfer(0, IDX_CONTROL, 0);
			check("done clear", rd, 32'h0);
			e = expect_fmt(cfg, vin);
			xfer(0, IDX_RESULT_HIGH, 0);
			check("result high", rd, {24'h0, e[15:8]});
			xfer(0, IDX_RESULT_LOW, 0);
			check("result low", rd, {24'h0, e[7:0]});
		end
		summarize(0);
	end
endmodule : tb_top
bind acf_converter acf_props u_acf_props (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .sample_hold(sample_hold), .gain_select(gain_select),
	.conversion_clock(conversion_clock));
`default_nettype wire
